// ---- inc/datapath_pkg.sv ----
// Shared widths, field positions, opcodes, states and carrier structs of the register datapath.
package datapath_pkg;
  // Word and character layout.
  localparam int WORD_W  = 24;
  localparam int CHAR_W  = 6;
  localparam int NCHAR   = 4;
  localparam int STORE_W = WORD_W + NCHAR;
  localparam int DBL_W   = 2 * WORD_W;
  localparam int CNT_W   = 6;
  // Address fields of the held instruction.
  localparam int ADDR_W   = 17;
  localparam int MW_W     = 15;
  localparam int MC_W     = 17;
  localparam int SUM_W    = 18;
  localparam int IND_W    = 18;
  localparam int B_LSB    = 15;
  localparam int B_MSB    = 16;
  localparam int IND_BIT  = 17;
  // Opcodes whose operation is masked by the auxiliary accumulator.
  localparam logic [5:0] OPC_MASK_A = 6'h06;
  localparam logic [5:0] OPC_MASK_B = 6'h07;
  localparam logic [5:0] OPC_MASK_C = 6'h27;
  // Extension register is fitted in this build.
  localparam logic EXT_FITTED = 1'b1;
  // Program counter and index register steps.
  localparam logic [ADDR_W-1:0] STEP_NORMAL = 17'h00001;
  localparam logic [ADDR_W-1:0] STEP_SKIP   = 17'h00002;
  localparam logic [MW_W-1:0]   IDX_ONE     = 15'h0001;

  // Datapath operations.
  typedef enum logic [4:0] {
    OP_NOP, OP_LDA, OP_LDQ, OP_ADD, OP_MASK, OP_SHA, OP_SHQ, OP_SHAQ,
    OP_MUL48, OP_DIV48, OP_IDX_INC, OP_IDX_DEC, OP_IDX_LD, OP_JZ,
    OP_FETCH, OP_READ, OP_WRITE, OP_IND, OP_IND_IDX
  } op_e;

  // Instruction completion kinds.
  typedef enum logic [1:0] {EXIT_NONE, EXIT_NORMAL, EXIT_SKIP, EXIT_JUMP} exit_e;

  // Console transfer destinations.
  typedef enum logic [1:0] {DST_A, DST_Q, DST_B1, DST_P} dst_e;

  // Sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_READ, ST_WRITE, ST_IND, ST_IND_IDX} state_e;

  // One command from main control.
  typedef struct packed {
    logic              valid;
    op_e               op;
    logic [5:0]        opcode;
    exit_e             exit_kind;
    logic              char_mode;
    logic              left;
    logic [CNT_W-1:0]  cnt;
    logic [DBL_W-1:0]  opnd;
  } cmd_s;

  // Request toward core storage.
  typedef struct packed {
    logic               req;
    logic               we;
    logic [ADDR_W-1:0]  addr;
    logic [STORE_W-1:0] wdata;
  } mem_req_s;

  // Answer from core storage.
  typedef struct packed {
    logic               ack;
    logic [STORE_W-1:0] rdata;
  } mem_rsp_s;

  // Operator console pins.
  typedef struct packed {
    logic              kb_active;
    logic              run;
    logic              sweep;
    logic              key_strobe;
    logic              transfer;
    logic              clear;
    logic              err_clear;
    dst_e              dst;
    logic [WORD_W-1:0] key_word;
  } console_s;
endpackage : datapath_pkg

// ---- rtl/word_parity.sv ----
// Odd parity generation and checking for the four characters of a storage word.
`timescale 1ns/1ps
`default_nettype none
module word_parity
  import datapath_pkg::*;
(
  // Word to be written.
  input  wire logic [WORD_W-1:0]  wr_word,
  output logic      [STORE_W-1:0] wr_store,
  // Word that was read.
  input  wire logic [STORE_W-1:0] rd_store,
  output logic      [WORD_W-1:0]  rd_word,
  output logic                    rd_err
);
  // Parity bits sit above the data, one per character, low character lowest.
  always_comb
  begin
    wr_store = {{NCHAR{1'b0}}, wr_word};
    rd_err   = 1'b0;
    for (int i = 0; i < NCHAR; i++)
    begin
      // Odd parity: the bit makes the count of ones in the character odd.
      wr_store[WORD_W+i] = ~^wr_word[i*CHAR_W +: CHAR_W];
      // A character plus its bit must hold an odd number of ones.
      if (~^{rd_store[WORD_W+i], rd_store[i*CHAR_W +: CHAR_W]})
      begin
        rd_err = 1'b1;
      end
    end
    rd_word = rd_store[WORD_W-1:0];
  end
endmodule : word_parity
`default_nettype wire

// ---- rtl/acc_shifter.sv ----
// Combinational shifter for the accumulator, auxiliary accumulator and the pair.
`timescale 1ns/1ps
`default_nettype none
module acc_shifter
  import datapath_pkg::*;
(
  // Operands.
  input  wire logic [WORD_W-1:0] a_in,
  input  wire logic [WORD_W-1:0] q_in,
  input  wire logic              left,
  input  wire logic [CNT_W-1:0]  cnt,
  // Results.
  output logic      [WORD_W-1:0] a_out,
  output logic      [WORD_W-1:0] q_out,
  output logic      [DBL_W-1:0]  aq_out
);
  // Right shift is end-off with sign fill; left shift is end-around.
  function automatic logic [DBL_W-1:0] shift_w(input logic [DBL_W-1:0] x, input int w,
                                              input logic lft, input logic [CNT_W-1:0] n);
    logic [DBL_W-1:0] r;
    r = x;
    // Every count the field can carry is honoured, so long rotates wrap fully.
    for (int k = 0; k < (1 << CNT_W); k++)
    begin
      if (k < int'(n))
      begin
        if (lft)
          r = (r << 1) | DBL_W'(r[w-1]);
        else
          r = (r >> 1) | (DBL_W'(r[w-1]) << (w - 1));
      end
    end
    if (w < DBL_W)
      r = r & ((DBL_W'(1) << w) - DBL_W'(1));
    return r;
  endfunction : shift_w

  logic [DBL_W-1:0] a_wide; // Accumulator shifted alone; upper half is zero.
  logic [DBL_W-1:0] q_wide; // Auxiliary accumulator shifted alone.

  // Each register alone, or the pair with the accumulator as upper half.
  always_comb
  begin
    a_wide = shift_w({{WORD_W{1'b0}}, a_in}, WORD_W, left, cnt);
    q_wide = shift_w({{WORD_W{1'b0}}, q_in}, WORD_W, left, cnt);
    a_out  = a_wide[WORD_W-1:0];
    q_out  = q_wide[WORD_W-1:0];
    aq_out = shift_w({a_in, q_in}, DBL_W, left, cnt);
  end
endmodule : acc_shifter
`default_nettype wire

// ---- rtl/cpu_register_datapath.sv ----
// Register datapath of the central processor: accumulators, index, program and console registers.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_datapath
  import datapath_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    srst,
  // Command from main control.
  input  wire datapath_pkg::cmd_s      cmd,
  output logic                         cmd_ready,
  output logic                         cmd_done,
  // Core storage.
  output datapath_pkg::mem_req_s       mem_req,
  input  wire datapath_pkg::mem_rsp_s  mem_rsp,
  // Operator console.
  input  wire datapath_pkg::console_s  console,
  output logic [WORD_W-1:0]            display,
  output logic                         parity_err,
  // Register views.
  output logic [WORD_W-1:0]            acc,
  output logic [WORD_W-1:0]            aux,
  output logic [DBL_W-1:0]             ext,
  output logic [ADDR_W-1:0]            pc,
  output logic [WORD_W-1:0]            instr
);
  // Architectural registers.
  logic [WORD_W-1:0]  a_q;                // Accumulator.
  logic [WORD_W-1:0]  q_q;                // Auxiliary accumulator.
  logic [DBL_W-1:0]   e_q;                // Extension register, upper and lower halves.
  logic [ADDR_W-1:0]  p_q;                // Program address counter.
  logic [WORD_W-1:0]  f_q;                // Instruction register.
  logic [MW_W-1:0]    b_q [1:3];          // Index registers.
  logic [WORD_W-1:0]  c_q;                // Communication register.
  logic               err_q;              // Sticky parity error.
  state_e             st_q;               // Storage sequencer.
  // Console synchronisers and edge memory.
  console_s           con_m_q;            // First stage, read only by the second.
  console_s           con_q;              // Synchronised console.
  logic [2:0]         prev_q;             // Previous key, transfer, clear levels.
  logic               key_ev, xfer_ev, clr_ev;
  // Storage path.
  logic [STORE_W-1:0] wr_store;
  logic [WORD_W-1:0]  rd_word;
  logic               rd_err;
  logic               rd_done;
  // Shifter results.
  logic [WORD_W-1:0]  sh_a, sh_q;
  logic [DBL_W-1:0]   sh_aq;
  // Effective address and arithmetic.
  logic [ADDR_W-1:0]  ea;
  logic [WORD_W-1:0]  mask;
  logic [2*DBL_W-1:0] prod;
  logic [2*DBL_W-1:0] dvd;
  logic               take;
  logic               a_zero;

  // One's complement sum with end-around carry.
  function automatic logic [WORD_W-1:0] oc_add(input logic [WORD_W-1:0] x,
                                               input logic [WORD_W-1:0] y);
    logic [WORD_W:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]};
  endfunction : oc_add

  // Index sum: both addends sign-extended, then cut to the address width.
  function automatic logic [ADDR_W-1:0] idx_sum(input logic [MC_W-1:0] m, input logic chr,
                                                input logic [MW_W-1:0] b);
    logic [SUM_W-1:0] mx;
    logic [SUM_W-1:0] bx;
    mx = chr ? {m[MC_W-1], m} : {{(SUM_W-MW_W){m[MW_W-1]}}, m[MW_W-1:0]};
    bx = {{(SUM_W-MW_W){b[MW_W-1]}}, b};
    return ADDR_W'(mx + bx);
  endfunction : idx_sum

  // Parity codec and shifter.
  word_parity u_par (
    .wr_word  (a_q),
    .wr_store (wr_store),
    .rd_store (mem_rsp.rdata),
    .rd_word  (rd_word),
    .rd_err   (rd_err)
  );

  acc_shifter u_sh (
    .a_in   (a_q),
    .q_in   (q_q),
    .left   (cmd.left),
    .cnt    (cmd.cnt),
    .a_out  (sh_a),
    .q_out  (sh_q),
    .aq_out (sh_aq)
  );

  // Effective address from the held instruction, index designator in bits 16:15.
  always_comb
  begin
    logic [1:0] bs;
    bs = f_q[B_MSB:B_LSB];
    if (bs == 2'b00)
      ea = cmd.char_mode ? f_q[MC_W-1:0] : {{(ADDR_W-MW_W){1'b0}}, f_q[MW_W-1:0]};
    else
      ea = idx_sum(f_q[MC_W-1:0], cmd.char_mode, b_q[bs]);
  end

  // Mask and wide arithmetic.
  always_comb
  begin
    // The auxiliary accumulator masks only the three listed opcodes.
    if (cmd.opcode == OPC_MASK_A || cmd.opcode == OPC_MASK_B || cmd.opcode == OPC_MASK_C)
      mask = q_q;
    else
      mask = {WORD_W{1'b1}};
    prod   = {{DBL_W{1'b0}}, a_q, q_q} * {{DBL_W{1'b0}}, cmd.opnd};
    dvd    = {a_q, q_q, e_q};
    a_zero = (a_q == {WORD_W{1'b0}}) || (a_q == {WORD_W{1'b1}});
  end

  // Handshake and storage request.
  assign take      = cmd.valid && (st_q == ST_IDLE);
  assign cmd_ready = (st_q == ST_IDLE);
  assign rd_done   = mem_rsp.ack && (st_q != ST_IDLE);

  // Storage request registered from the sequencer.
  always_ff @(posedge clk)
  begin
    if (srst)
      mem_req <= '0;
    else if (take && cmd.op == OP_FETCH)
      mem_req <= '{req: 1'b1, we: 1'b0, addr: p_q, wdata: '0};
    else if (take && (cmd.op == OP_READ || cmd.op == OP_IND))
      mem_req <= '{req: 1'b1, we: 1'b0, addr: ea, wdata: '0};
    else if (take && cmd.op == OP_IND_IDX)
      mem_req <= '{req: 1'b1, we: 1'b0, addr: {2'b00, f_q[MW_W-1:0]}, wdata: '0};
    else if (take && cmd.op == OP_WRITE)
      mem_req <= '{req: 1'b1, we: 1'b1, addr: ea, wdata: wr_store};
    else if (mem_rsp.ack)
      mem_req <= '0;
  end

  // Sequencer: storage operations wait for the acknowledge.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q   <= ST_IDLE;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
        begin
          if (take)
          begin
            unique case (cmd.op)
              OP_FETCH:   st_q <= ST_FETCH;
              OP_READ:    st_q <= ST_READ;
              OP_WRITE:   st_q <= ST_WRITE;
              OP_IND:     st_q <= ST_IND;
              OP_IND_IDX: st_q <= ST_IND_IDX;
              default:    st_q <= ST_IDLE;
            endcase
          end
        end
        ST_FETCH, ST_READ, ST_WRITE, ST_IND, ST_IND_IDX:
        begin
          // Return to idle once storage answers.
          if (mem_rsp.ack)
            st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Completion pulse: register commands at once, storage commands on the answer.
  always_ff @(posedge clk)
  begin
    if (srst)
      cmd_done <= 1'b0;
    else
      cmd_done <= (take && cmd.op < OP_FETCH) || rd_done;
  end

  // Accumulator and auxiliary accumulator.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      a_q <= '0;
      q_q <= '0;
    end
    else if (take)
    begin
      unique case (cmd.op)
        OP_LDA:   a_q <= cmd.opnd[WORD_W-1:0];
        OP_LDQ:   q_q <= cmd.opnd[WORD_W-1:0];
        OP_ADD:   a_q <= oc_add(a_q, cmd.opnd[WORD_W-1:0]);
        OP_MASK:  a_q <= cmd.opnd[WORD_W-1:0] & mask;
        OP_SHA:   a_q <= sh_a;
        OP_SHQ:   q_q <= sh_q;
        OP_SHAQ:  {a_q, q_q} <= sh_aq;
        OP_MUL48:
        begin
          if (EXT_FITTED)
            {a_q, q_q} <= prod[2*DBL_W-1:DBL_W];
        end
        OP_DIV48:
        begin
          if (EXT_FITTED && cmd.opnd != '0)
            {a_q, q_q} <= DBL_W'(dvd / {{DBL_W{1'b0}}, cmd.opnd});
        end
        default:  a_q <= a_q;
      endcase
    end
    else if (st_q == ST_READ && mem_rsp.ack)
      a_q <= rd_word;
    else if (xfer_ev && con_q.dst == DST_A)
      a_q <= c_q;
    else if (xfer_ev && con_q.dst == DST_Q)
      q_q <= c_q;
  end

  // Extension register.
  always_ff @(posedge clk)
  begin
    if (srst)
      e_q <= '0;
    else if (take && EXT_FITTED && cmd.op == OP_MUL48)
      e_q <= prod[DBL_W-1:0];
    else if (take && EXT_FITTED && cmd.op == OP_DIV48 && cmd.opnd != '0)
      e_q <= DBL_W'(dvd % {{DBL_W{1'b0}}, cmd.opnd});
  end

  // Program address counter.
  always_ff @(posedge clk)
  begin
    if (srst)
      p_q <= '0;
    else if (take && cmd.op == OP_JZ)
      p_q <= a_zero ? {2'b00, f_q[MW_W-1:0]} : p_q + STEP_NORMAL;
    else if (take && cmd.op < OP_FETCH)
    begin
      unique case (cmd.exit_kind)
        EXIT_NORMAL: p_q <= p_q + STEP_NORMAL;
        EXIT_SKIP:   p_q <= p_q + STEP_SKIP;
        EXIT_JUMP:   p_q <= {2'b00, f_q[MW_W-1:0]};
        EXIT_NONE:   p_q <= p_q;
      endcase
    end
    else if (xfer_ev && con_q.dst == DST_P)
      p_q <= c_q[ADDR_W-1:0];
  end

  // Instruction register: fetch and the two indirect forms.
  always_ff @(posedge clk)
  begin
    if (srst)
      f_q <= '0;
    else if (mem_rsp.ack && st_q == ST_FETCH)
      f_q <= rd_word;
    else if (mem_rsp.ack && st_q == ST_IND)
      f_q[IND_W-1:0] <= rd_word[IND_W-1:0];
    else if (mem_rsp.ack && st_q == ST_IND_IDX)
    begin
      f_q[MW_W-1:0]  <= rd_word[MW_W-1:0];
      f_q[IND_BIT]   <= rd_word[IND_BIT];
    end
  end

  // Index registers, selected by the held instruction.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 1; i <= 3; i++)
        b_q[i] <= '0;
    end
    else if (take && f_q[B_MSB:B_LSB] != 2'b00)
    begin
      unique case (cmd.op)
        OP_IDX_INC: b_q[f_q[B_MSB:B_LSB]] <= b_q[f_q[B_MSB:B_LSB]] + IDX_ONE;
        OP_IDX_DEC: b_q[f_q[B_MSB:B_LSB]] <= b_q[f_q[B_MSB:B_LSB]] - IDX_ONE;
        OP_IDX_LD:  b_q[f_q[B_MSB:B_LSB]] <= cmd.opnd[MW_W-1:0];
        default:    b_q[1] <= b_q[1];
      endcase
    end
    else if (xfer_ev && con_q.dst == DST_B1)
      b_q[1] <= c_q[MW_W-1:0];
  end

  // Console pins pass two flip-flops before any logic reads them.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      con_m_q <= '0;
      con_q   <= '0;
      prev_q  <= '0;
    end
    else
    begin
      con_m_q <= console;
      con_q   <= con_m_q;
      prev_q  <= {con_q.key_strobe, con_q.transfer, con_q.clear};
    end
  end

  // Rising edges of the synchronised console controls.
  assign key_ev  = con_q.key_strobe && !prev_q[2];
  assign xfer_ev = con_q.transfer && !prev_q[1];
  assign clr_ev  = con_q.clear && !prev_q[0];

  // Communication register: keyboard entry and sweep capture win over clear.
  always_ff @(posedge clk)
  begin
    if (srst)
      c_q <= '0;
    else if (key_ev)
      c_q <= con_q.key_word;
    else if (rd_done && !mem_req.we && con_q.sweep)
      c_q <= rd_word;
    else if (clr_ev)
      c_q <= '0;
  end

  // Sticky parity error; a new error wins over the clear.
  always_ff @(posedge clk)
  begin
    if (srst)
      err_q <= 1'b0;
    else if (rd_done && !mem_req.we && rd_err)
      err_q <= 1'b1;
    else if (con_q.err_clear)
      err_q <= 1'b0;
  end

  // Console display selection, registered.
  always_ff @(posedge clk)
  begin
    if (srst)
      display <= '0;
    else if (con_q.kb_active)
      display <= c_q;
    else if (!con_q.run)
      display <= f_q;
    else
      display <= a_q;
  end

  // Register views.
  assign parity_err = err_q;
  assign acc        = a_q;
  assign aux        = q_q;
  assign ext        = e_q;
  assign pc         = p_q;
  assign instr      = f_q;
endmodule : cpu_register_datapath
`default_nettype wire

// ---- verif/cpu_register_datapath_sva.sv ----
// Concurrent checks on the ports of the register datapath.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_datapath_sva
  import datapath_pkg::*;
(
  // Clock and reset.
  input wire logic                     clk,
  input wire logic                     srst,
  // Command and storage sides.
  input wire datapath_pkg::cmd_s       cmd,
  input wire logic                     cmd_ready,
  input wire logic                     cmd_done,
  input wire datapath_pkg::mem_req_s   mem_req,
  input wire datapath_pkg::mem_rsp_s   mem_rsp,
  // Register views.
  input wire logic                     parity_err,
  input wire logic [WORD_W-1:0]        acc,
  input wire logic [ADDR_W-1:0]        pc,
  input wire logic [WORD_W-1:0]        instr
);
  logic                     take;   // A command is taken at this edge.
  logic                     reg_op; // A one-cycle op whose exit steps the counter.
  logic [NCHAR-1:0]         rd_odd; // Per character, read word has odd ones.
  logic [NCHAR-1:0]         wr_odd; // Per character, write word has odd ones.
  logic signed [WORD_W-1:0] acc_s;  // Signed view so the shift fills with sign.
  assign take   = cmd.valid && cmd_ready;
  assign reg_op = take && cmd.op < OP_FETCH && cmd.op != OP_JZ;
  assign acc_s  = acc;
  // Odd parity per character on both storage directions.
  always_comb
  begin
    for (int i = 0; i < NCHAR; i++)
    begin
      rd_odd[i] = ^{mem_rsp.rdata[WORD_W+i], mem_rsp.rdata[CHAR_W*i +: CHAR_W]};
      wr_odd[i] = ^{mem_req.wdata[WORD_W+i], mem_req.wdata[CHAR_W*i +: CHAR_W]};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_pc_normal: assert property (reg_op && cmd.exit_kind == EXIT_NORMAL
    |=> pc == $past(pc) + STEP_NORMAL) else $error("pc not stepped by one");
  a_pc_skip: assert property (reg_op && cmd.exit_kind == EXIT_SKIP
    |=> pc == $past(pc) + STEP_SKIP) else $error("pc not stepped by two");
  a_pc_jump: assert property (reg_op && cmd.exit_kind == EXIT_JUMP
    |=> pc == {2'b00, $past(instr[MW_W-1:0])}) else $error("pc not loaded");
  a_fetch_addr: assert property (take && cmd.op == OP_FETCH
    |=> mem_req.req && !mem_req.we && mem_req.addr == $past(pc)) else $error("bad fetch");
  a_req_held: assert property (mem_req.req && !mem_rsp.ack
    |=> mem_req.req && $stable(mem_req.addr) && $stable(mem_req.wdata)) else $error("req moved");
  a_ack_done: assert property (mem_req.req && mem_rsp.ack
    |=> cmd_done && !mem_req.req) else $error("no completion");
  a_write_parity: assert property (mem_req.req && mem_req.we
    |-> wr_odd == 4'hF) else $error("write parity wrong");
  a_parity_flag: assert property (mem_rsp.ack && !mem_req.we && rd_odd != 4'hF
    |=> parity_err) else $error("parity error missed");
  a_shift_right: assert property (take && cmd.op == OP_SHA && !cmd.left
    |=> $signed(acc) == ($past(acc_s) >>> $past(cmd.cnt))) else $error("right shift wrong");
  a_rotate_left: assert property (take && cmd.op == OP_SHA && cmd.left && cmd.cnt == 6'h01
    |=> acc == {$past(acc[WORD_W-2:0]), $past(acc[WORD_W-1])}) else $error("rotate wrong");
endmodule : cpu_register_datapath_sva
`default_nettype wire

// ---- verif/core_store_model.sv ----
// Behavioural core storage that answers each request after a set wait.
`timescale 1ns/1ps
`default_nettype none
module core_store_model
  import datapath_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    srst,
  // Storage port of the datapath.
  input  wire datapath_pkg::mem_req_s  mem_req,
  output var  datapath_pkg::mem_rsp_s  mem_rsp,
  // Wait length and a parity fault on reads.
  input  wire logic [3:0]              lat,
  input  wire logic                    flip
);
  logic [STORE_W-1:0] store [64]; // Words, indexed by low address bits.
  logic [STORE_W-1:0] last_w;     // Last word written.
  logic [STORE_W-1:0] data_q;     // Word on the return lines.
  logic [3:0]         wait_q;     // Cycles waited on this request.
  logic               ack_q;      // One-cycle answer.
  // Released return lines show the inverse of the last word, never a stale copy.
  assign mem_rsp = '{ack: ack_q, rdata: ack_q ? data_q : ~data_q};
  // Count the wait out, answer once, then let the request drop.
  always @(posedge clk)
  begin
    if (srst)
    begin
      ack_q  <= 1'b0;
      wait_q <= 4'h0;
      data_q <= 28'h0;
    end
    else if (ack_q)
    begin
      ack_q  <= 1'b0;
      wait_q <= 4'h0;
    end
    else if (mem_req.req && wait_q < lat)
      wait_q <= wait_q + 4'h1;
    else if (mem_req.req)
    begin
      ack_q  <= 1'b1;
      data_q <= store[mem_req.addr[5:0]] ^ {3'h0, flip, 24'h0};
      if (mem_req.we)
      begin
        store[mem_req.addr[5:0]] <= mem_req.wdata;
        last_w <= mem_req.wdata;
      end
    end
  end
endmodule : core_store_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the register datapath beside a core storage model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import datapath_pkg::*;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  cmd_s              cmd = '0;
  console_s          console = '0;
  logic [3:0]        lat = 4'h0;
  logic              flip = 1'b0;
  logic [5:0]        opc = 6'h00;
  logic              cmd_ready, cmd_done, parity_err;
  mem_req_s          mem_req;
  mem_rsp_s          mem_rsp;
  logic [WORD_W-1:0] display, acc, aux, instr;
  logic [DBL_W-1:0]  ext;
  logic [ADDR_W-1:0] pc;
  int                n_fail = 0;
  int                n_compared = 0;
  int                cycles = 0;
  always #12.5 clk = ~clk;
  cpu_register_datapath dut (.clk, .srst, .cmd, .cmd_ready, .cmd_done, .mem_req, .mem_rsp,
    .console, .display, .parity_err, .acc, .aux, .ext, .pc, .instr);
  core_store_model store_u (.clk, .srst, .mem_req, .mem_rsp, .lat, .flip);
  // Cut a hang short well past the expected run length.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  // Odd parity bit for each character.
  function automatic logic [3:0] par(input logic [23:0] w);
    for (int i = 0; i < 4; i++)
      par[i] = ~^w[6*i +: 6];
  endfunction : par
  // Offer one command for one edge, then wait, bounded, for its completion pulse.
  task automatic issue(input op_e op, input exit_e ex, input logic lft,
                       input logic [5:0] n, input logic [47:0] d);
    int k;
    @(negedge clk);
    cmd = '{1'b1, op, opc, ex, 1'b0, lft, n, d};
    @(negedge clk);
    cmd.valid = 1'b0;
    k = 0;
    while (cmd_done !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    chk("cmd_done", 48'h1, 48'(cmd_done));
  endtask : issue
  // A fetch from a slow store, then a jump to its address field.
  task automatic t_fetch_jump();
    lat = 4'h3;
    store_u.store[0] = {par(24'h000123), 24'h000123};
    issue(OP_FETCH, EXIT_NONE, 1'b0, 6'h00, 48'h0);
    chk("instr", 48'h000123, 48'(instr));
    issue(OP_NOP, EXIT_JUMP, 1'b0, 6'h00, 48'h0);
    chk("pc", 48'h123, 48'(pc));
    $display("t_fetch_jump finished");
  endtask : t_fetch_jump
  // A load, then an add with end-around carry, normal then skip exit.
  task automatic t_arith();
    issue(OP_LDA, EXIT_NORMAL, 1'b0, 6'h00, 48'h5);
    chk("pc", 48'h124, 48'(pc));
    issue(OP_ADD, EXIT_SKIP, 1'b0, 6'h00, 48'hFFFFFE);
    chk("acc", 48'h4, 48'(acc));
    chk("pc", 48'h126, 48'(pc));
    issue(OP_LDQ, EXIT_NONE, 1'b0, 6'h00, 48'h00FF00);
    opc = 6'h27;
    issue(OP_MASK, EXIT_NONE, 1'b0, 6'h00, 48'h123456);
    opc = 6'h00;
    chk("acc", 48'h003400, 48'(acc));
    $display("t_arith finished");
  endtask : t_arith
  // Sign-filled right shift, rotate left, pair shift, then a store of the result.
  task automatic t_shift();
    issue(OP_LDA, EXIT_NONE, 1'b0, 6'h00, 48'h800010);
    issue(OP_SHA, EXIT_NONE, 1'b0, 6'h04, 48'h0);
    chk("acc", 48'hF80001, 48'(acc));
    issue(OP_SHA, EXIT_NONE, 1'b1, 6'h01, 48'h0);
    chk("acc", 48'hF00003, 48'(acc));
    issue(OP_LDQ, EXIT_NONE, 1'b0, 6'h00, 48'h1);
    issue(OP_SHAQ, EXIT_NONE, 1'b0, 6'h01, 48'h0);
    chk("pair", 48'hF80001800000, {acc, aux});
    issue(OP_WRITE, EXIT_NONE, 1'b0, 6'h00, 48'h0);
    chk("stored", {20'h0, par(24'hF80001), 24'hF80001}, 48'(store_u.last_w));
    $display("t_shift finished");
  endtask : t_shift
  // Double-length multiply into the extension, then divide back out of it.
  task automatic t_mul_div();
    issue(OP_LDA, EXIT_NONE, 1'b0, 6'h00, 48'h0);
    issue(OP_LDQ, EXIT_NONE, 1'b0, 6'h00, 48'h3);
    issue(OP_MUL48, EXIT_NONE, 1'b0, 6'h00, 48'h5);
    chk("ext", 48'hF, ext);
    chk("pair", 48'h0, {acc, aux});
    issue(OP_DIV48, EXIT_NONE, 1'b0, 6'h00, 48'h4);
    chk("pair", 48'h3, {acc, aux});
    chk("ext", 48'h3, ext);
    $display("t_mul_div finished");
  endtask : t_mul_div
  // A read with a broken parity bit during a sweep, then the flag is cleared.
  task automatic t_read_fault();
    console.kb_active = 1'b1;
    console.sweep = 1'b1;
    for (int i = 0; i < 64; i++)
      store_u.store[i] = {par(24'h5A3C96), 24'h5A3C96};
    lat = 4'h4;
    flip = 1'b1;
    wait_n(5);
    issue(OP_READ, EXIT_NONE, 1'b0, 6'h00, 48'h0);
    wait_n(2);
    chk("parity_err", 48'h1, 48'(parity_err));
    chk("display", 48'h5A3C96, 48'(display));
    flip = 1'b0;
    console.sweep = 1'b0;
    console.err_clear = 1'b1;
    wait_n(5);
    chk("parity_err", 48'h0, 48'(parity_err));
    console.err_clear = 1'b0;
    $display("t_read_fault finished");
  endtask : t_read_fault
  // Key entry held until transfer, cleared, then the instruction display.
  task automatic t_console();
    console.key_word = 24'h13579B;
    console.dst = DST_A;
    console.key_strobe = 1'b1;
    wait_n(3);
    console.key_strobe = 1'b0;
    wait_n(5);
    chk("display", 48'h13579B, 48'(display));
    chk("acc", 48'h5A3C96, 48'(acc));
    console.transfer = 1'b1;
    wait_n(3);
    console.transfer = 1'b0;
    wait_n(5);
    chk("acc", 48'h13579B, 48'(acc));
    console.clear = 1'b1;
    wait_n(3);
    console.clear = 1'b0;
    wait_n(5);
    chk("display", 48'h0, 48'(display));
    console.kb_active = 1'b0;
    wait_n(5);
    chk("display", 48'h000123, 48'(display));
    $display("t_console finished");
  endtask : t_console
  // A negative index steps the address back; indirect rewrites the address fields.
  task automatic t_index();
    store_u.store[6'h26] = {par(24'h008005), 24'h008005};
    store_u.store[4] = {par(24'h000042), 24'h000042};
    issue(OP_FETCH, EXIT_NONE, 1'b0, 6'h00, 48'h0);
    issue(OP_IDX_LD, EXIT_NONE, 1'b0, 6'h00, 48'h7FFE);
    issue(OP_IDX_INC, EXIT_NONE, 1'b0, 6'h00, 48'h0);
    issue(OP_READ, EXIT_NONE, 1'b0, 6'h00, 48'h0);
    chk("acc", 48'h000042, 48'(acc));
    issue(OP_IND, EXIT_NONE, 1'b0, 6'h00, 48'h0);
    chk("instr", 48'h000042, 48'(instr));
    $display("t_index finished");
  endtask : t_index
  // Main sequence.
  initial
  begin
    wait_n(6);
    srst = 1'b0;
    chk("cmd_ready", 48'h1, 48'(cmd_ready));
    t_fetch_jump();
    t_arith();
    t_shift();
    t_mul_div();
    t_read_fault();
    t_console();
    t_index();
    report_and_stop();
  end
endmodule : testbench
bind cpu_register_datapath cpu_register_datapath_sva chk_u (.clk, .srst, .cmd, .cmd_ready,
  .cmd_done, .mem_req, .mem_rsp, .parity_err, .acc, .pc, .instr);
`default_nettype wire
